// [design/crank_consts.svh]
// Field offsets and constants for the crank sensor threshold and blanking block
`ifndef CRANK_CONSTS_SVH
`define CRANK_CONSTS_SVH

`define CSTB_THR_MSB 7
`define CSTB_THR_LSB 4
`define CSTB_BLK_MSB 3
`define CSTB_BLK_LSB 0
`define CSTB_RUN_RESET 8'h50
`define CSTB_CRANK_RESET 8'h00
`define CSTB_BLK_STEPS 32

`endif

// [design/cstb_pkg.sv]
// Types for the crank sensor threshold and blanking block
package cstb_pkg;

  typedef struct packed {
    logic [7:0] running;
    logic [7:0] cranking;
    logic singleEnded;
    logic refDisconnect;
    logic lowReference;
    logic autoThreshold;
  } cstb_cfg_t;

  typedef enum logic [1:0] {
    CSTB_IDLE,
    CSTB_BLANK
  } cstb_phase_t;

  typedef struct packed {
    logic cmpSync1;
    logic cmpSync2;
    logic toothOut;
    cstb_phase_t phase;
    logic [23:0] pulseCount;
    logic [23:0] lastRefWidth;
    logic [23:0] blankCount;
    logic [4:0] divCount;
    logic tach_pulse_output;
    logic [3:0] thresholdCode;
  } cstb_state_t;

endpackage : cstb_pkg

// [design/cstb_crank_sensor.sv]
// Crank sensor conditioner control: threshold select, blanking one-shot, tach divider
`timescale 1ns/100ps
`include "crank_consts.svh"

module cstb_crank_sensor #(
  parameter int CountWidth = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire cstb_pkg::cstb_cfg_t cfg,
  input wire logic [3:0] peakCode,
  input wire logic comparatorRaw,
  input wire logic tachDivEnable,
  input wire logic [4:0] tachDivide,
  output logic [3:0] dacCode,
  output logic singleEndedSelect,
  output logic refDisconnect,
  output logic conditionedToothOutput,
  output logic tachPulseOutput
);
  import cstb_pkg::*;

  // The state struct fixes the counter width, so any other value cannot be served
  if (CountWidth != 24) begin : g_bad_width
    $error("CountWidth must match the state struct width of 24");
  end

  // ****************************************************************
  // Register selection
  // ****************************************************************
  logic crankActive;
  logic [7:0] selected;
  logic [3:0] blankCode;
  logic [3:0] nextThreshold;

  always_comb begin
    crankActive = (cfg.cranking != 8'h00);
    selected = crankActive ? cfg.cranking : cfg.running;
    blankCode = selected[`CSTB_BLK_MSB:`CSTB_BLK_LSB];
    // Automatic mode tracks the last digitised peak amplitude
    nextThreshold = cfg.autoThreshold ? peakCode
                                      : selected[`CSTB_THR_MSB:`CSTB_THR_LSB];
  end

  // ****************************************************************
  // State
  // ****************************************************************
  cstb_state_t state;
  cstb_state_t next_state;
  logic rawLevel;
  logic refLevel;
  logic [27:0] blankProduct;
  logic [23:0] blankLength;
  logic [4:0] divTarget;

  always_comb begin
    next_state = state;
    next_state.cmpSync1 = comparatorRaw;
    next_state.cmpSync2 = state.cmpSync1;
    next_state.thresholdCode = nextThreshold;
    rawLevel = state.cmpSync2;
    // Reference pulse: high time normally, low time with an elongated tooth wheel
    refLevel = cfg.lowReference ? 1'b0 : 1'b1;
    // Each code step is 1/32 of the reference width (3.125 percent)
    blankProduct = 28'(state.lastRefWidth) * 28'(blankCode);
    blankLength = {1'b0, blankProduct[27:5]};
    divTarget = tachDivide - 5'h01;

    if (state.pulseCount != 24'hffffff) begin
      next_state.pulseCount = state.pulseCount + 24'h000001;
    end

    unique case (state.phase)
      CSTB_IDLE: begin
        if (rawLevel != state.toothOut) begin
          next_state.toothOut = rawLevel;
          next_state.pulseCount = 24'h000001;
          // Width of the pulse just ended becomes the new reference if that pulse was at the reference level
          if (state.toothOut == refLevel) begin
            next_state.lastRefWidth = state.pulseCount;
          end
          if (blankLength != 24'h000000) begin
            next_state.blankCount = blankLength;
            next_state.phase = CSTB_BLANK;
          end
          // Tach divider counts rising tooth edges; divide 0 means 32
          if (rawLevel) begin
            if (state.divCount == divTarget) begin
              next_state.divCount = 5'h00;
              next_state.tach_pulse_output = ~state.tach_pulse_output;
            end else begin
              next_state.divCount = state.divCount + 5'h01;
            end
          end
        end
      end
      CSTB_BLANK: begin
        // Comparator changes are ignored here; level is re-examined on exit
        next_state.blankCount = state.blankCount - 24'h000001;
        if (state.blankCount == 24'h000001) begin
          next_state.phase = CSTB_IDLE;
        end
      end
      default: begin
        next_state.phase = CSTB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
      state.phase <= CSTB_IDLE;
      state.thresholdCode <= 4'h5;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    dacCode = state.thresholdCode;
    singleEndedSelect = cfg.singleEnded;
    refDisconnect = cfg.refDisconnect;
    conditionedToothOutput = state.toothOut;
    tachPulseOutput = tachDivEnable ? state.tach_pulse_output : 1'b0;
  end

endmodule : cstb_crank_sensor

// [tb/cstb_checker.sv]
// Port assertions for the crank sensor conditioner
`timescale 1ns/100ps
module cstb_checker (
  input wire logic clk,
  input wire logic rst,
  input wire cstb_pkg::cstb_cfg_t cfg,
  input wire logic [3:0] peakCode,
  input wire logic comparatorRaw,
  input wire logic tachDivEnable,
  input wire logic [4:0] tachDivide,
  input wire logic [3:0] dacCode,
  input wire logic singleEndedSelect,
  input wire logic refDisconnect,
  input wire logic conditionedToothOutput,
  input wire logic tachPulseOutput
);
  import cstb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_run_code: assert property (!cfg.autoThreshold && cfg.cranking == 8'h00 |=>
    dacCode == $past(cfg.running[7:4])) else $error("running code");
  a_crank_code: assert property (!cfg.autoThreshold && cfg.cranking != 8'h00 |=>
    dacCode == $past(cfg.cranking[7:4])) else $error("cranking code");
  a_auto_code: assert property (cfg.autoThreshold |=>
    dacCode == $past(peakCode)) else $error("auto code");
  a_se_copy: assert property (singleEndedSelect == cfg.singleEnded)
    else $error("single-ended");
  a_ref_copy: assert property (refDisconnect == cfg.refDisconnect)
    else $error("ref disconnect");
  a_reset_vals: assert property (disable iff (1'b0) rst |=>
    dacCode == 4'h5 && !conditionedToothOutput) else $error("reset values");
  // Tooth may only move to the level seen three edges earlier
  a_tooth_lag: assert property ($changed(conditionedToothOutput) |->
    conditionedToothOutput == $past(comparatorRaw, 3)) else $error("tooth lag");
  a_tach_idle: assert property (!tachDivEnable [*2] |-> !tachPulseOutput)
    else $error("tach idle");
endmodule : cstb_checker
bind cstb_crank_sensor cstb_checker i_chk (.*);

// [tb/cstb_sensor_model.sv]
// Reluctance sensor stand-in: 64-cycle half periods while turning
`timescale 1ns/100ps
module cstb_sensor_model (
  input wire logic clk,
  input wire logic run,
  output logic raw
);
  logic [6:0] cnt = 7'h00;
  // One-cycle dip early in each high half: the noise that blanking must hide
  assign raw = cnt[6] && cnt[5:0] != 6'h03;
  always @(negedge clk) cnt <= run ? cnt + 7'h01 : 7'h00;
endmodule : cstb_sensor_model

// [tb/tb_top.sv]
// Self-checking bench for the crank sensor conditioner
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module tb_top;
  import cstb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, tachEn = 1'b0;
  logic raw, lastTooth, tooth, seSel, refDis, tach;
  logic lastTach = 1'b0;
  int toothRises = 0, tachFlips = 0;
  logic [3:0] dac, peak = 4'h0;
  cstb_cfg_t cfg = 20'h50000;
  logic [31:0] seed = 32'h6c9f;
  int mismatches = 0, total_checks = 0, cycles = 0, runLen = 0, minRun = 99;
  initial forever #12.5 clk = !clk;
  cstb_sensor_model i_wheel (.clk(clk), .run(run), .raw(raw));
  cstb_crank_sensor i_dut (.clk(clk), .rst(rst), .cfg(cfg), .peakCode(peak), .comparatorRaw(raw),
    .tachDivEnable(tachEn), .tachDivide(5'h02), .dacCode(dac), .singleEndedSelect(seSel),
    .refDisconnect(refDis), .conditionedToothOutput(tooth), .tachPulseOutput(tach));
  // Shortest steady stretch of the tooth output; a leaked spike shows as 1
  always @(posedge clk) begin
    cycles++;
    if (tooth !== lastTooth) begin
      minRun = (runLen < minRun) ? runLen : minRun;
      runLen = 0;
    end
    runLen++;
    if (tooth === 1'b1 && lastTooth === 1'b0) toothRises++;
    if (tach !== lastTach) tachFlips++;
    lastTach = tach;
    lastTooth = tooth;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift
  function automatic logic [3:0] expCode(input cstb_cfg_t c);
    return c.autoThreshold ? peak : (c.cranking != 8'h00) ? c.cranking[7:4] : c.running[7:4];
  endfunction : expCode
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    `CHK(dac, 4'h5)
    for (int i = 0; i < 48; i++) begin
      seed = xorshift(seed);
      cfg = seed[19:0];
      cfg.autoThreshold = (i >= 40);
      peak = seed[23:20];
      if (i % 4 == 0) cfg.cranking = 8'h00;
      if (i == 1) cfg.cranking = 8'h01;
      @(negedge clk);
      `CHK(dac, expCode(cfg))
      `CHK({seSel, refDis}, {cfg.singleEnded, cfg.refDisconnect})
    end
    $display("thresholds done");
    tachEn = 1'b1;
    run = 1'b1;
    // Code 0 must pass the dip, code 8 must hide it
    // Third pass times blanking from the low pulse
    for (int k = 0; k < 3; k++) begin
      cfg = {4'h5, (k != 0) ? 4'h8 : 4'h0, 8'h00, 2'b00, k == 2, 1'b0};
      repeat (150) @(negedge clk);
      minRun = 99;
      repeat (300) @(negedge clk);
      `CHK(minRun >= 15, k != 0)
    end
    `CHK(tachFlips, toothRises / 2)
    $display("blanking done");
    results();
  end
endmodule : tb_top
